// ==== bench/ltcb_host_model.sv ====
// Register host model: write and read strobes toward the bank
`timescale 1ns/1ps
module ltcb_host_model
(
   // Clock
   input  wire logic           mclk,
   // Register access
   output ltcb_pkg::ltcb_req_t req,
   input  wire logic [15:0]    rdData
);
   import ltcb_pkg::*;
   initial req = '0;
   ////////////////////////////////////////////////////////////
   // One-cycle write; data inverted once released so stale data never looks valid
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge mclk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge mclk);
      req.wrStb <= 1'b0;
      req.wrData <= ~d;
   endtask : wr
   // Read strobe; data taken once the sampling edge has settled
   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      @(posedge mclk);
      req.addr <= a;
      req.rdStb <= 1'b1;
      @(posedge mclk);
      req.rdStb <= 1'b0;
      #1 d = rdData;
   endtask : rd
endmodule : ltcb_host_model

// ==== bench/tb_top.sv ====
// Testbench of the limit threshold compare bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin badCount++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
   import ltcb_pkg::*;
   logic        mclk = 0, srst = 1, diagRead = 0, trimChecksumErr = 0;
   logic        alertLatchSelect = 0, averagedAlertSelect = 0, shuntRangeSelect = 0;
   ltcb_req_t   req;
   ltcb_meas_t  rawMeas = '0, avgMeas = '0;
   ltcb_flags_t limitFlags;
   logic [15:0] rdData, d;
   logic        trimChecksumOk, alertActive;
   int          badCount = 0, cmpCount = 0, cycles = 0;
   // Mapped offsets, then one unmapped place
   logic [5:0]  ofs [8] = '{6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h3E, 6'h20};
   logic [15:0] rstV [8] = '{16'h7FFF, 16'h8000, 16'h7FFF, 16'h0000, 16'h7FF0, 16'hFFFF, 16'h4142, 16'h0000};
   logic [15:0] onesV [8] = '{16'hFFFF, 16'hFFFF, 16'h7FFF, 16'h7FFF, 16'hFFF0, 16'hFFFF, 16'h4142, 16'h0000};
   ////////////////////////////////////////////////////////////
   ltcb_bank u_dut (.mclk, .srst, .req, .rdData, .rawMeas, .avgMeas, .alertLatchSelect, .averagedAlertSelect,
      .shuntRangeSelect, .diagRead, .trimChecksumErr, .limitFlags, .trimChecksumOk, .alertActive);
   ltcb_host_model u_host (.mclk, .req, .rdData);
   // Clock and hang guard
   always #2 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         badCount++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////
   // One measurement pulse on the raw or averaged source
   task automatic meas(input logic avg, input logic [15:0] s, b, input logic [11:0] t, input logic [23:0] p);
      @(posedge mclk);
      if (avg)
         avgMeas <= '{1'b1, s, b, t, p};
      else
         rawMeas <= '{1'b1, s, b, t, p};
      @(posedge mclk);
      rawMeas.valid <= 1'b0;
      avgMeas.valid <= 1'b0;
      @(posedge mclk);
      #1;
   endtask : meas
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      foreach (ofs[i])
      begin
         u_host.rd(ofs[i], d);
         `CHK("reset value", rstV[i], d)
      end
      // Ones everywhere: reserved bits and the code place must not take them
      foreach (ofs[i])
      begin
         u_host.wr(ofs[i], 16'hFFFF);
         u_host.rd(ofs[i], d);
         `CHK("write back", onesV[i], d)
      end
      u_host.wr(6'h0C, 16'hFFFF); // high kept above low
      u_host.wr(6'h0D, 16'hFFFE);
      u_host.wr(6'h0E, 16'h0100);
      u_host.wr(6'h0F, 16'h0010);
      u_host.wr(6'h10, 16'h0100);
      u_host.wr(6'h11, 16'h0010);
      shuntRangeSelect <= 1'b1;
      meas(1'b0, 16'h0000, 16'h0200, 12'h011, 24'h001100);
      `CHK("flags over", 6'b110101, limitFlags)
      `CHK("alert", 1'b1, alertActive)
      // Values on the limits do not trip: comparisons are strict
      meas(1'b0, 16'hFFFD, 16'h0005, 12'h010, 24'h001000);
      `CHK("flags under", 6'b001010, limitFlags)
      meas(1'b0, 16'hFFFF, 16'h0010, 12'h000, 24'h000000);
      `CHK("flags clear", 6'b000000, limitFlags)
      @(posedge mclk);
      alertLatchSelect <= 1'b1;
      meas(1'b0, 16'h0000, 16'h0200, 12'h011, 24'h001100);
      meas(1'b0, 16'hFFFF, 16'h0010, 12'h000, 24'h000000);
      `CHK("latched", 6'b110101, limitFlags)
      @(posedge mclk);
      diagRead <= 1'b1;
      @(posedge mclk);
      diagRead <= 1'b0;
      @(posedge mclk);
      #1 `CHK("diag read", 6'b000000, limitFlags)
      @(posedge mclk);
      alertLatchSelect <= 1'b0;
      averagedAlertSelect <= 1'b1;
      meas(1'b0, 16'h0000, 16'h0200, 12'h011, 24'h001100);
      `CHK("raw ignored", 6'b000000, limitFlags)
      meas(1'b1, 16'h0000, 16'h0200, 12'h011, 24'h001100);
      `CHK("averaged", 6'b110101, limitFlags)
      `CHK("checksum ok", 1'b1, trimChecksumOk)
      @(posedge mclk);
      trimChecksumErr <= 1'b1;
      repeat (5) @(posedge mclk);
      #1 `CHK("checksum err", 1'b0, trimChecksumOk)
      results();
   end
endmodule : tb_top

// ==== src/ltcb_bank.sv ====
// Limit threshold register bank with comparators and flag keeping
`timescale 1ns/1ps
`include "ltcb_consts.svh"
module ltcb_bank
(
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               srst,
   // Register access
   input  wire ltcb_pkg::ltcb_req_t req,
   output logic [15:0]             rdData,
   // Measurements
   input  wire ltcb_pkg::ltcb_meas_t rawMeas,
   input  wire ltcb_pkg::ltcb_meas_t avgMeas,
   // Configuration from neighbouring registers
   input  wire logic               alertLatchSelect,
   input  wire logic               averagedAlertSelect,
   input  wire logic               shuntRangeSelect,
   input  wire logic               diagRead,
   input  wire logic               trimChecksumErr,
   // Status out
   output ltcb_pkg::ltcb_flags_t   limitFlags,
   output logic                    trimChecksumOk,
   output logic                    alertActive
);
   import ltcb_pkg::*;

   // How the bank behaves, in short:
   //  - Thresholds load on a write strobe; reads answer one cycle later from a flop
   //  - Reserved bits are never stored, so they cannot read back as anything but zero
   //  - The maker code is a constant on the read path; no write place exists for it
   //  - All six comparisons are strict; a value equal to its limit never trips
   //  - Shunt limits compare as signed codes, so a negative high limit trips at zero
   //  - The range select only changes what one code means, both sides scale alike
   //  - Bus limits drop bit 15; the bus result uses bits 14 to 0 only
   //  - The power limit meets the upper sixteen bits of the 24-bit power result
   //  - Flags move only on a sample of the selected source, or on a diagnostic read
   //  - Latched flags gather until read; a hit in the read cycle survives it
   //  - Transparent flags follow the latest sample; a cleared fault drops at once
   //  - Host must keep the shunt high limit above the low one when both are negative
   //  - The checksum error crosses two flops; the bit stays low until reset

   ltcb_state_t st_q;
   ltcb_state_t st_d;
   ltcb_meas_t  meas;
   ltcb_flags_t hit;
   logic        errSync1_q;
   logic        errSync2_q;

   ////////////////////////////////////////////////////////////////
   // Checksum error comes from the trim memory domain, synchronise it
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         errSync1_q <= 1'b0;
         errSync2_q <= 1'b0;
      end
      else
      begin
         errSync1_q <= trimChecksumErr;
         errSync2_q <= errSync1_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Comparison source: averaged or raw value
   assign meas = averagedAlertSelect ? avgMeas : rawMeas;

   // Limit comparisons; shunt range only rescales, codes compare directly
   always_comb
   begin
      hit.shuntOver  = $signed(meas.shunt) > $signed(st_q.shuntHigh);
      hit.shuntUnder = $signed(meas.shunt) < $signed(st_q.shuntLow);
      hit.busOver    = meas.bus[`LTCB_BUS_MSB:0] > st_q.busHigh;
      hit.busUnder   = meas.bus[`LTCB_BUS_MSB:0] < st_q.busLow;
      hit.tempOver   = $signed(meas.temp) > $signed(st_q.tempLimit);
      hit.powerOver  = meas.power[23:`LTCB_POWER_LSB] > st_q.powerLimit;
   end

   ////////////////////////////////////////////////////////////////
   // Next state: register writes, flags and read data
   always_comb
   begin
      st_d = st_q;
      if (req.wrStb)
      begin
         unique case (req.addr)
            `LTCB_OFS_SHUNT_HIGH: st_d.shuntHigh  = req.wrData;
            `LTCB_OFS_SHUNT_LOW:  st_d.shuntLow   = req.wrData;
            `LTCB_OFS_BUS_HIGH:   st_d.busHigh    = req.wrData[`LTCB_BUS_MSB:0];
            `LTCB_OFS_BUS_LOW:    st_d.busLow     = req.wrData[`LTCB_BUS_MSB:0];
            `LTCB_OFS_TEMP:       st_d.tempLimit  = req.wrData[15:`LTCB_TEMP_LSB];
            `LTCB_OFS_POWER:      st_d.powerLimit = req.wrData;
            default:              st_d = st_q; // Maker code and others ignore writes
         endcase
      end
      // Latched flags clear on diagnostic read; a fresh hit wins over clear
      if (meas.valid)
      begin
         if (alertLatchSelect)
            st_d.flags = (diagRead ? '0 : st_q.flags) | hit;
         else
            st_d.flags = hit;
      end
      else if (alertLatchSelect && diagRead)
         st_d.flags = '0;
      // Error only ever pulls the bit low until reset
      if (errSync2_q)
         st_d.checksumOk = 1'b0;
      if (req.rdStb)
      begin
         unique case (req.addr)
            `LTCB_OFS_SHUNT_HIGH: st_d.rdData = st_q.shuntHigh;
            `LTCB_OFS_SHUNT_LOW:  st_d.rdData = st_q.shuntLow;
            `LTCB_OFS_BUS_HIGH:   st_d.rdData = {1'b0, st_q.busHigh};
            `LTCB_OFS_BUS_LOW:    st_d.rdData = {1'b0, st_q.busLow};
            `LTCB_OFS_TEMP:       st_d.rdData = {st_q.tempLimit, 4'h0};
            `LTCB_OFS_POWER:      st_d.rdData = st_q.powerLimit;
            `LTCB_OFS_MAKER:      st_d.rdData = `LTCB_MAKER_CODE; // Arbitrary code
            default:              st_d.rdData = 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         st_q            <= '0;
         st_q.shuntHigh  <= `LTCB_RST_SHUNT_HIGH;
         st_q.shuntLow   <= `LTCB_RST_SHUNT_LOW;
         st_q.busHigh    <= `LTCB_RST_BUS_HIGH;
         st_q.busLow     <= `LTCB_RST_BUS_LOW;
         st_q.tempLimit  <= `LTCB_RST_TEMP;
         st_q.powerLimit <= `LTCB_RST_POWER;
         st_q.checksumOk <= 1'b1;
      end
      else
         st_q <= st_d;
   end

   // Outputs come from flops; alertActive is an OR of the flag flops
   assign rdData         = st_q.rdData;
   assign limitFlags     = st_q.flags;
   assign trimChecksumOk = st_q.checksumOk;
   assign alertActive    = |st_q.flags;

   ////////////////////////////////////////////////////////////////
   // Checks
   sequence s_latchedHit;
      alertLatchSelect && meas.valid && hit.shuntOver;
   endsequence
   sequence s_noRead;
      !diagRead;
   endsequence
   // Write then read of one place, one idle cycle between, as the host does it
   sequence s_wrRd(logic [5:0] ofs);
      (req.wrStb && req.addr == ofs) ##1 !req.wrStb ##1 (req.rdStb && req.addr == ofs);
   endsequence

   a_latch_hold: assert property (@(posedge mclk) disable iff (srst)
      s_latchedHit ##1 (alertLatchSelect && !diagRead) |-> limitFlags.shuntOver)
      else $error("latched shunt flag lost before read");
   a_shunt_over_flag: assert property (@(posedge mclk) disable iff (srst)
      (meas.valid && $signed(meas.shunt) > $signed(st_q.shuntHigh)) |=> limitFlags.shuntOver)
      else $error("shunt over flag not set");
   a_transparent_clear: assert property (@(posedge mclk) disable iff (srst)
      (meas.valid && !alertLatchSelect && !hit.busUnder) |=> !limitFlags.busUnder)
      else $error("transparent flag not cleared");
   a_checksum_low: assert property (@(posedge mclk) disable iff (srst)
      errSync2_q |=> !trimChecksumOk)
      else $error("checksum bit not cleared");
   a_bus_high_rsvd: assert property (@(posedge mclk) disable iff (srst)
      (req.rdStb && req.addr == `LTCB_OFS_BUS_HIGH) |=> rdData[15] == 1'b0)
      else $error("bus high bit 15 not zero");
   a_temp_rsvd_zero: assert property (@(posedge mclk) disable iff (srst)
      (req.rdStb && req.addr == `LTCB_OFS_TEMP) |=> rdData[3:0] == 4'h0)
      else $error("temperature reserved bits not zero");
   a_maker_fixed: assert property (@(posedge mclk) disable iff (srst)
      (req.rdStb && req.addr == `LTCB_OFS_MAKER) |=> rdData == `LTCB_MAKER_CODE)
      else $error("maker code wrong");
   a_power_compare: assert property (@(posedge mclk) disable iff (srst)
      (meas.valid && meas.power[23:8] <= st_q.powerLimit && !alertLatchSelect) |=> !limitFlags.powerOver)
      else $error("power flag set below limit");
   a_shunt_write: assert property (@(posedge mclk) disable iff (srst)
      s_wrRd(`LTCB_OFS_SHUNT_HIGH) |=> rdData == $past(req.wrData, 3))
      else $error("shunt high readback wrong");
   a_latch_read_clr: assert property (@(posedge mclk) disable iff (srst)
      (alertLatchSelect && diagRead && !meas.valid) |=> limitFlags == '0)
      else $error("diagnostic read did not clear");

   ////////////////////////////////////////////////////////////////
   // Set checks per flag, written from the thresholds, not from the hit vector
   a_shunt_zero_neg: assert property (@(posedge mclk) disable iff (srst)
      (meas.valid && st_q.shuntHigh[15] && meas.shunt == 16'h0000) |=> limitFlags.shuntOver)
      else $error("zero shunt did not trip a negative limit");
   a_shunt_under_set: assert property (@(posedge mclk) disable iff (srst)
      (meas.valid && $signed(meas.shunt) < $signed(st_q.shuntLow)) |=> limitFlags.shuntUnder)
      else $error("shunt under flag not set");
   a_bus_over_set: assert property (@(posedge mclk) disable iff (srst)
      (meas.valid && meas.bus[14:0] > st_q.busHigh) |=> limitFlags.busOver)
      else $error("bus over flag not set");
   a_bus_under_set: assert property (@(posedge mclk) disable iff (srst)
      (meas.valid && meas.bus[14:0] < st_q.busLow) |=> limitFlags.busUnder)
      else $error("bus under flag not set");
   a_temp_over_set: assert property (@(posedge mclk) disable iff (srst)
      (meas.valid && $signed(meas.temp) > $signed(st_q.tempLimit)) |=> limitFlags.tempOver)
      else $error("temperature over flag not set");
   a_power_over_set: assert property (@(posedge mclk) disable iff (srst)
      (meas.valid && meas.power[23:8] > st_q.powerLimit) |=> limitFlags.powerOver)
      else $error("power over flag not set");

   ////////////////////////////////////////////////////////////////
   // Transparent mode: a flag drops with the sample that no longer trips it
   sequence s_transparent;
      meas.valid && !alertLatchSelect;
   endsequence

   a_shunt_over_clr: assert property (@(posedge mclk) disable iff (srst)
      (s_transparent ##0 $signed(meas.shunt) <= $signed(st_q.shuntHigh)) |=> !limitFlags.shuntOver)
      else $error("shunt over flag not cleared");
   a_shunt_under_clr: assert property (@(posedge mclk) disable iff (srst)
      (s_transparent ##0 $signed(meas.shunt) >= $signed(st_q.shuntLow)) |=> !limitFlags.shuntUnder)
      else $error("shunt under flag not cleared");
   a_bus_over_clr: assert property (@(posedge mclk) disable iff (srst)
      (s_transparent ##0 meas.bus[14:0] <= st_q.busHigh) |=> !limitFlags.busOver)
      else $error("bus over flag not cleared");
   a_temp_over_clr: assert property (@(posedge mclk) disable iff (srst)
      (s_transparent ##0 $signed(meas.temp) <= $signed(st_q.tempLimit)) |=> !limitFlags.tempOver)
      else $error("temperature over flag not cleared");

   ////////////////////////////////////////////////////////////////
   // Latched mode: flags only gather until a diagnostic read; a hit beats the read
   sequence s_latchedIdle;
      alertLatchSelect && !diagRead;
   endsequence
   sequence s_latchedRead;
      alertLatchSelect && diagRead && meas.valid;
   endsequence

   a_latch_keep: assert property (@(posedge mclk) disable iff (srst)
      s_latchedIdle |=> (limitFlags & $past(limitFlags)) == $past(limitFlags))
      else $error("latched flag dropped without a read");
   a_alert_keep: assert property (@(posedge mclk) disable iff (srst)
      (s_latchedIdle ##0 alertActive) |=> alertActive)
      else $error("latched alert dropped without a read");
   a_alert_clear: assert property (@(posedge mclk) disable iff (srst)
      (alertLatchSelect && diagRead && !meas.valid) |=> !alertActive)
      else $error("alert still active after diagnostic read");
   a_latch_set_wins: assert property (@(posedge mclk) disable iff (srst)
      (s_latchedRead ##0 $signed(meas.shunt) > $signed(st_q.shuntHigh)) |=> limitFlags.shuntOver)
      else $error("shunt over hit lost to a diagnostic read");
   a_latch_under_wins: assert property (@(posedge mclk) disable iff (srst)
      (s_latchedRead ##0 $signed(meas.shunt) < $signed(st_q.shuntLow)) |=> limitFlags.shuntUnder)
      else $error("shunt under hit lost to a diagnostic read");
   a_latch_busov_wins: assert property (@(posedge mclk) disable iff (srst)
      (s_latchedRead ##0 meas.bus[14:0] > st_q.busHigh) |=> limitFlags.busOver)
      else $error("bus over hit lost to a diagnostic read");
   a_latch_busun_wins: assert property (@(posedge mclk) disable iff (srst)
      (s_latchedRead ##0 meas.bus[14:0] < st_q.busLow) |=> limitFlags.busUnder)
      else $error("bus under hit lost to a diagnostic read");
   a_latch_temp_wins: assert property (@(posedge mclk) disable iff (srst)
      (s_latchedRead ##0 $signed(meas.temp) > $signed(st_q.tempLimit)) |=> limitFlags.tempOver)
      else $error("temperature hit lost to a diagnostic read");
   a_latch_power_wins: assert property (@(posedge mclk) disable iff (srst)
      (s_latchedRead ##0 meas.power[23:8] > st_q.powerLimit) |=> limitFlags.powerOver)
      else $error("power hit lost to a diagnostic read");

   ////////////////////////////////////////////////////////////////
   // Flags rest between samples; the unselected source and the range bit never move them
   a_flags_idle: assert property (@(posedge mclk) disable iff (srst)
      (!meas.valid && !diagRead) |=> $stable(limitFlags))
      else $error("flags moved without a sample");
   a_avg_source: assert property (@(posedge mclk) disable iff (srst)
      (averagedAlertSelect && !avgMeas.valid && !diagRead) |=> $stable(limitFlags))
      else $error("flags moved without an averaged sample");
   a_raw_source: assert property (@(posedge mclk) disable iff (srst)
      (!averagedAlertSelect && !rawMeas.valid && !diagRead) |=> $stable(limitFlags))
      else $error("flags moved without a raw sample");
   a_range_neutral: assert property (@(posedge mclk) disable iff (srst)
      ($changed(shuntRangeSelect) && !meas.valid && !diagRead) |=> $stable(limitFlags))
      else $error("range change moved the flags");
   a_avg_shunt: assert property (@(posedge mclk) disable iff (srst)
      (averagedAlertSelect && avgMeas.valid && $signed(avgMeas.shunt) > $signed(st_q.shuntHigh))
      |=> limitFlags.shuntOver)
      else $error("averaged shunt sample did not trip");
   a_raw_shunt: assert property (@(posedge mclk) disable iff (srst)
      (!averagedAlertSelect && rawMeas.valid && $signed(rawMeas.shunt) > $signed(st_q.shuntHigh))
      |=> limitFlags.shuntOver)
      else $error("raw shunt sample did not trip");
   a_avg_temp: assert property (@(posedge mclk) disable iff (srst)
      (averagedAlertSelect && avgMeas.valid && $signed(avgMeas.temp) > $signed(st_q.tempLimit))
      |=> limitFlags.tempOver)
      else $error("averaged temperature sample did not trip");

   ////////////////////////////////////////////////////////////////
   // Trim checksum bit: one out of reset, sticky low after an error
   a_checksum_sticky: assert property (@(posedge mclk) disable iff (srst)
      !trimChecksumOk |=> !trimChecksumOk)
      else $error("checksum bit rose without reset");
   a_checksum_idle: assert property (@(posedge mclk) disable iff (srst)
      (!errSync2_q && trimChecksumOk) |=> trimChecksumOk)
      else $error("checksum bit fell without an error");
   a_reset_status: assert property (@(posedge mclk)
      srst |=> (trimChecksumOk && limitFlags == '0 && rdData == 16'h0000))
      else $error("status wrong after reset");
   a_reset_limits: assert property (@(posedge mclk)
      srst |=> (st_q.shuntHigh == `LTCB_RST_SHUNT_HIGH && st_q.shuntLow == `LTCB_RST_SHUNT_LOW
         && st_q.busHigh == `LTCB_RST_BUS_HIGH && st_q.busLow == `LTCB_RST_BUS_LOW
         && st_q.tempLimit == `LTCB_RST_TEMP && st_q.powerLimit == `LTCB_RST_POWER))
      else $error("thresholds wrong after reset");

   ////////////////////////////////////////////////////////////////
   // Read path: reserved bits read zero, each threshold place reads back what was written
   a_bus_low_rsvd: assert property (@(posedge mclk) disable iff (srst)
      (req.rdStb && req.addr == `LTCB_OFS_BUS_LOW) |=> rdData[15] == 1'b0)
      else $error("bus low bit 15 not zero");
   a_read_hold: assert property (@(posedge mclk) disable iff (srst)
      !req.rdStb |=> $stable(rdData))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (@(posedge mclk) disable iff (srst)
      (req.rdStb && !(req.addr inside {`LTCB_OFS_SHUNT_HIGH, `LTCB_OFS_SHUNT_LOW, `LTCB_OFS_BUS_HIGH,
         `LTCB_OFS_BUS_LOW, `LTCB_OFS_TEMP, `LTCB_OFS_POWER, `LTCB_OFS_MAKER})) |=> rdData == 16'h0000)
      else $error("unmapped place not zero");
   a_shunt_low_write: assert property (@(posedge mclk) disable iff (srst)
      s_wrRd(`LTCB_OFS_SHUNT_LOW) |=> rdData == $past(req.wrData, 3))
      else $error("shunt low readback wrong");
   a_bus_high_write: assert property (@(posedge mclk) disable iff (srst)
      s_wrRd(`LTCB_OFS_BUS_HIGH) |=> rdData == {1'b0, $past(req.wrData[14:0], 3)})
      else $error("bus high readback wrong");
   a_bus_low_write: assert property (@(posedge mclk) disable iff (srst)
      s_wrRd(`LTCB_OFS_BUS_LOW) |=> rdData == {1'b0, $past(req.wrData[14:0], 3)})
      else $error("bus low readback wrong");
   a_temp_write: assert property (@(posedge mclk) disable iff (srst)
      s_wrRd(`LTCB_OFS_TEMP) |=> rdData == {$past(req.wrData[15:4], 3), 4'h0})
      else $error("temperature readback wrong");
   a_power_write: assert property (@(posedge mclk) disable iff (srst)
      s_wrRd(`LTCB_OFS_POWER) |=> rdData == $past(req.wrData, 3))
      else $error("power readback wrong");
   a_maker_write: assert property (@(posedge mclk) disable iff (srst)
      s_wrRd(`LTCB_OFS_MAKER) |=> rdData == `LTCB_MAKER_CODE)
      else $error("maker code took a write");
endmodule : ltcb_bank

// ==== src/ltcb_consts.svh ====
// Constants of the limit threshold compare bank: offsets, fields, reset values
// Notes on behaviour
// - Checksum ok bit resets one, clears on error
// - Negative shunt high limit trips at zero
// - Signed shunt high threshold, 0xC, reset 7FFF
// - Signed shunt low threshold, 0xD, reset 8000
// - Shunt threshold shares shunt result scaling
// - Bus high threshold 15 bits, 0xE, 7FFF
// - Bus low threshold 15 bits, 0xF, zero
// - Bus thresholds compare directly on raw codes
// - Signed temperature limit bits 15-4, reset 7FF
// - Temperature bits 3-0 ignore writes, read zero
// - Unsigned power limit, 0x11, reset FFFF
// - Power limit step is 256 power steps
// - Read-only maker code at 0x3E
// - Each comparison sets its own flag
// - Latched flags hold until diagnostic read
// - Averaged option selects averaged comparison values
`ifndef LTCB_CONSTS_SVH
`define LTCB_CONSTS_SVH
`define LTCB_OFS_SHUNT_HIGH   6'h0C
`define LTCB_OFS_SHUNT_LOW    6'h0D
`define LTCB_OFS_BUS_HIGH     6'h0E
`define LTCB_OFS_BUS_LOW      6'h0F
`define LTCB_OFS_TEMP         6'h10
`define LTCB_OFS_POWER        6'h11
`define LTCB_OFS_MAKER        6'h3E
`define LTCB_RST_SHUNT_HIGH   16'h7FFF
`define LTCB_RST_SHUNT_LOW    16'h8000
`define LTCB_RST_BUS_HIGH     15'h7FFF
`define LTCB_RST_BUS_LOW      15'h0000
`define LTCB_RST_TEMP         12'h7FF
`define LTCB_RST_POWER        16'hFFFF
`define LTCB_MAKER_CODE       16'h4142 // Arbitrary value, stands in for the real maker code
`define LTCB_BUS_MSB          14
`define LTCB_TEMP_LSB         4
`define LTCB_POWER_LSB        8
`endif

// ==== src/ltcb_pkg.sv ====
// Types of the limit threshold compare bank
package ltcb_pkg;
   // Register access from the serial front end
   typedef struct packed {
      logic        wrStb;
      logic        rdStb;
      logic [5:0]  addr;
      logic [15:0] wrData;
   } ltcb_req_t;
   // One measurement sample set
   typedef struct packed {
      logic        valid;
      logic [15:0] shunt;
      logic [15:0] bus;
      logic [11:0] temp;
      logic [23:0] power;
   } ltcb_meas_t;
   // Limit flags
   typedef struct packed {
      logic tempOver;
      logic shuntOver;
      logic shuntUnder;
      logic busOver;
      logic busUnder;
      logic powerOver;
   } ltcb_flags_t;
   // Module state except the checksum error synchroniser flops
   typedef struct packed {
      logic [15:0] shuntHigh;
      logic [15:0] shuntLow;
      logic [14:0] busHigh;
      logic [14:0] busLow;
      logic [11:0] tempLimit;
      logic [15:0] powerLimit;
      logic        checksumOk;
      ltcb_flags_t flags;
      logic [15:0] rdData;
   } ltcb_state_t;
endpackage : ltcb_pkg
